// ===== verilog/lai_pkg.sv
// Purpose: shared constants of the line alarm interrupt logic
// Assumes: one aclk equals one line bit period
// Notes:   register offsets are byte addresses on AXI4-Lite
package lai_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int          LAI_CHANNELS       = 2;      // line channels
  localparam int          LAI_ADDR_W         = 8;      // byte address width
  localparam int          LAI_DMO_QUIET_BITS = 128;    // quiet bit periods
  localparam int          LAI_CNT_W          = 8;      // quiet counter width

  // ---------------------------------------------------------------
  // register map: channel n at base + n * stride
  // ---------------------------------------------------------------
  localparam logic [7:0]  LAI_ENABLE_OFS     = 8'h00;  // enable register
  localparam logic [7:0]  LAI_STATUS_OFS     = 8'h04;  // status register
  localparam logic [7:0]  LAI_CHAN_STRIDE    = 8'h10;  // per channel
  localparam int          LAI_CHAN_BIT       = 4;      // address bit of channel

  // ---------------------------------------------------------------
  // field positions and resets
  // ---------------------------------------------------------------
  localparam int          LAI_PAT_IE_BIT     = 0;      // test pattern enable
  localparam int          LAI_LOS_IE_BIT     = 1;      // signal loss enable
  localparam int          LAI_DMO_IE_BIT     = 6;      // driver monitor enable
  localparam int          LAI_DMO_ST_BIT     = 6;      // driver monitor status
  localparam logic [7:0]  LAI_ENABLE_RST     = 8'h00;  // enable reset value
  localparam logic [7:0]  LAI_ENABLE_MASK    = 8'h43;  // writable enable bits

  // ---------------------------------------------------------------
  // bus answers
  // ---------------------------------------------------------------
  localparam logic [1:0]  LAI_RESP_OKAY      = 2'h0;
  localparam logic [1:0]  LAI_RESP_SLVERR    = 2'h2;

endpackage

// ===== verilog/lai_chan.sv
// Purpose: one line channel: enables, driver monitor, change events
// Assumes: line inputs synchronous to aclk, one bit per cycle
// Notes:   irq is a one-cycle pulse per detected change
`timescale 1ns/1ps
module lai_chan import lai_pkg::*; (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       en_wr,
  input  wire logic [7:0] en_wdata,
  input  wire logic       tx_line_pos,
  input  wire logic       tx_line_neg,
  input  wire logic       rx_signal_loss,
  input  wire logic       test_pattern_detect,
  output logic      [7:0] enable_q,
  output logic            driver_monitor_alarm,
  output logic            irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]           en;      // enable register image
    logic [LAI_CNT_W-1:0] quiet;   // bits without bipolar pulse
    logic                 dmo;     // driver monitor alarm
    logic                 los_d;   // previous signal loss
    logic                 pat_d;   // previous pattern detect
    logic                 irq;     // change event pulse
  } lai_chan_st_t;

  lai_chan_st_t st_r;             // registered state
  lai_chan_st_t st_nxt;           // next state
  logic         pulse;            // bipolar pulse this bit
  logic         dmo_next;         // alarm value next bit

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // exactly one rail high is a valid bipolar mark
    pulse = tx_line_pos ^ tx_line_neg;
    dmo_next = st_r.dmo;
    if (en_wr) begin
      // bits 6, 1, 0 writable; reserved stay zero
      st_nxt.en = en_wdata & LAI_ENABLE_MASK;
    end
    if (pulse) begin
      // any activity clears at once
      st_nxt.quiet = '0;
      dmo_next = 1'b0;
    end else if (st_r.quiet == LAI_CNT_W'(LAI_DMO_QUIET_BITS - 1)) begin
      // 128th consecutive quiet bit
      dmo_next = 1'b1;
    end else begin
      st_nxt.quiet = st_r.quiet + 1'b1;
    end
    st_nxt.dmo = dmo_next;
    st_nxt.los_d = rx_signal_loss;
    st_nxt.pat_d = test_pattern_detect;
    // both edges of each condition count as a change
    st_nxt.irq =
      (st_r.en[LAI_LOS_IE_BIT] & (rx_signal_loss != st_r.los_d)) |
      (st_r.en[LAI_PAT_IE_BIT] & (test_pattern_detect != st_r.pat_d)) |
      (st_r.en[LAI_DMO_IE_BIT] & (dmo_next != st_r.dmo));
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.en <= LAI_ENABLE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign enable_q = st_r.en;
  assign driver_monitor_alarm = st_r.dmo;
  assign irq = st_r.irq;

endmodule

// ===== verilog/lai_top.sv
// Purpose: line alarm interrupt logic for two line channels, AXI4-Lite slave
// Assumes: aclk is the line bit clock; line inputs synchronous to it
// Notes:   one write and one read at a time; unmapped address gives SLVERR
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module lai_top import lai_pkg::*; #(
  parameter int CHANNELS = LAI_CHANNELS
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // write address
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [LAI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  // write data
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  // write response
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output logic      [1:0]            s_axi_bresp,
  // read address
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  input  wire logic [LAI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  // read data
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic      [31:0]           s_axi_rdata,
  output logic      [1:0]            s_axi_rresp,
  // line side, one bit per channel
  input  wire logic [CHANNELS-1:0]   tx_line_pos,
  input  wire logic [CHANNELS-1:0]   tx_line_neg,
  input  wire logic [CHANNELS-1:0]   rx_signal_loss,
  input  wire logic [CHANNELS-1:0]   test_pattern_detect,
  // per-channel change event pulses
  output logic      [CHANNELS-1:0]   line_alarm_irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        bvalid;          // write answer pending
    logic [1:0]  bresp;           // write answer code
    logic        rvalid;          // read answer pending
    logic [31:0] rdata;           // read data
    logic [1:0]  rresp;           // read answer code
  } lai_bus_st_t;

  lai_bus_st_t        st_r;        // registered bus state
  lai_bus_st_t        st_nxt;      // next bus state
  logic               wr_take;     // write address and data taken
  logic               rd_take;     // read address taken
  logic [CHANNELS-1:0] en_wr;      // per-channel enable write strobe
  logic [7:0]         enable_q [CHANNELS];  // enable images
  logic [CHANNELS-1:0] dmo;        // driver monitor alarms
  logic               wr_hit;      // write hits a mapped register
  logic               rd_hit;      // read hits a mapped register
  logic [31:0]        rd_word;     // decoded read word

  // ---------------------------------------------------------------
  // handshakes: write needs both channels, answer slot free
  // ---------------------------------------------------------------
  // taking address and data together keeps one write in flight
  assign wr_take       = s_axi_awvalid & s_axi_wvalid & ~st_r.bvalid;
  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;
  assign rd_take       = s_axi_arvalid & ~st_r.rvalid;
  assign s_axi_arready = rd_take;

  // ---------------------------------------------------------------
  // per-channel instances, write strobe chosen by the full enable address
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_chan
      // byte 0 carries the whole 8-bit register
      assign en_wr[gi] = wr_take & s_axi_wstrb[0] &
        (s_axi_awaddr == LAI_ADDR_W'(LAI_ENABLE_OFS + LAI_CHAN_STRIDE * gi));
      lai_chan u_chan (
        .aclk                 (aclk),
        .aresetn              (aresetn),
        .en_wr                (en_wr[gi]),
        .en_wdata             (s_axi_wdata[7:0]),
        .tx_line_pos          (tx_line_pos[gi]),
        .tx_line_neg          (tx_line_neg[gi]),
        .rx_signal_loss       (rx_signal_loss[gi]),
        .test_pattern_detect  (test_pattern_detect[gi]),
        .enable_q             (enable_q[gi]),
        .driver_monitor_alarm (dmo[gi]),
        .irq                  (line_alarm_irq[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // address decode for reads and writes
  // ---------------------------------------------------------------
  always_comb begin
    wr_hit = 1'b0;
    rd_hit = 1'b0;
    rd_word = '0;
    for (int c = 0; c < CHANNELS; c++) begin
      // enable register is writable and readable
      if (s_axi_awaddr == LAI_ADDR_W'(LAI_ENABLE_OFS + LAI_CHAN_STRIDE * c)) begin
        wr_hit = 1'b1;
      end
      // status register accepts writes and ignores them
      if (s_axi_awaddr == LAI_ADDR_W'(LAI_STATUS_OFS + LAI_CHAN_STRIDE * c)) begin
        wr_hit = 1'b1;
      end
      if (s_axi_araddr == LAI_ADDR_W'(LAI_ENABLE_OFS + LAI_CHAN_STRIDE * c)) begin
        rd_hit = 1'b1;
        rd_word = {24'h000000, enable_q[c]};
      end
      if (s_axi_araddr == LAI_ADDR_W'(LAI_STATUS_OFS + LAI_CHAN_STRIDE * c)) begin
        rd_hit = 1'b1;
        rd_word = '0;
        rd_word[LAI_DMO_ST_BIT] = dmo[c];
      end
    end
  end

  // ---------------------------------------------------------------
  // answer channels
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // answer leaves once the master accepts it
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (wr_take) begin
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = wr_hit ? LAI_RESP_OKAY : LAI_RESP_SLVERR;
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (rd_take) begin
      // data frozen in the answer so the master sees one sample
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd_hit ? rd_word : 32'h00000000;
      st_nxt.rresp = rd_hit ? LAI_RESP_OKAY : LAI_RESP_SLVERR;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp  = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata  = st_r.rdata;
  assign s_axi_rresp  = st_r.rresp;

endmodule

// ===== test/lai_asserts.sv
// Purpose: port-level checks of the line alarm interrupt logic
// Assumes: one aclk per line bit; channel 0 is mirrored
// Notes:   quiet counter and enables are rebuilt from port traffic
`timescale 1ns/1ps
module lai_chk import lai_pkg::*; #(
  parameter int CHANNELS = LAI_CHANNELS
) (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  s_axi_awvalid,
  input wire logic [LAI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic                  s_axi_wvalid,
  input wire logic [31:0]           s_axi_wdata,
  input wire logic [3:0]            s_axi_wstrb,
  input wire logic                  s_axi_bvalid,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_arvalid,
  input wire logic [LAI_ADDR_W-1:0] s_axi_araddr,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic [1:0]            s_axi_rresp,
  input wire logic [CHANNELS-1:0]   tx_line_pos,
  input wire logic [CHANNELS-1:0]   tx_line_neg,
  input wire logic [CHANNELS-1:0]   rx_signal_loss,
  input wire logic [CHANNELS-1:0]   test_pattern_detect,
  input wire logic [CHANNELS-1:0]   line_alarm_irq
);
  // ------------------------------------------------------------
  // mirrors of channel 0
  // ------------------------------------------------------------
  logic [7:0] qcnt_r;   // quiet samples so far
  logic       alarm_r;  // expected driver alarm
  logic [7:0] en_r;     // expected enables

  // saturating quiet count; a pulse wins over everything
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      qcnt_r  <= 8'h00;
      alarm_r <= 1'b0;
      en_r    <= LAI_ENABLE_RST;
    end else begin
      if (tx_line_pos[0] ^ tx_line_neg[0]) begin
        qcnt_r  <= 8'h00;
        alarm_r <= 1'b0;
      end else if (qcnt_r == 8'h7f) begin
        alarm_r <= 1'b1;
      end else begin
        qcnt_r <= qcnt_r + 8'h01;
      end
      if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && s_axi_wstrb[0] &&
          s_axi_awaddr == LAI_ENABLE_OFS) begin
        en_r <= s_axi_wdata[7:0] & LAI_ENABLE_MASK;
      end
    end
  end

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && !s_axi_rvalid;
  endsequence

  chk_wr_answer: assert property (s_wr_take |=> s_axi_bvalid)
    else $error("write not answered next cycle");
  chk_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  chk_rd_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  chk_status_bit: assert property ($rose(s_axi_rvalid) &&
    $past(s_axi_araddr) == LAI_STATUS_OFS |-> s_axi_rdata == {25'h0, $past(alarm_r), 6'h00})
    else $error("status word differs from alarm");
  chk_unmapped_err: assert property ($rose(s_axi_rvalid) &&
    ($past(s_axi_araddr) & 8'heb) != 8'h00 |-> s_axi_rresp == LAI_RESP_SLVERR)
    else $error("unmapped read not refused");
  chk_los_irq: assert property (en_r[1] && $past(en_r[1]) &&
    $changed(rx_signal_loss[0]) |=> line_alarm_irq[0])
    else $error("signal loss change missed");
  chk_pat_irq: assert property (en_r[0] && $past(en_r[0]) &&
    $changed(test_pattern_detect[0]) |=> line_alarm_irq[0])
    else $error("test pattern change missed");
  chk_dmo_irq: assert property (en_r[6] && $past(en_r[6]) &&
    $changed(alarm_r) |-> line_alarm_irq[0])
    else $error("driver alarm change missed");
  chk_irq_cause: assert property (line_alarm_irq[0] |-> $changed(alarm_r) ||
    $past(rx_signal_loss[0]) != $past(rx_signal_loss[0], 2) ||
    $past(test_pattern_detect[0]) != $past(test_pattern_detect[0], 2))
    else $error("event pulse without cause");
endmodule

bind lai_top lai_chk #(.CHANNELS(CHANNELS)) i_lai_chk (.*);

// ===== test/lai_line_model.sv
// Purpose: transmit line seen by the driver monitor
// Assumes: all-ones data, so marks alternate rails every bit
// Notes:   quiet puts both rails at space level, as a broken driver would
`timescale 1ns/1ps
module lai_line_model #(
  parameter int CHANNELS = 2
) (
  input  wire logic                aclk,
  input  wire logic [CHANNELS-1:0] quiet,
  output logic      [CHANNELS-1:0] pos,
  output logic      [CHANNELS-1:0] neg
);
  logic tog_r = 1'b0;  // mark inversion phase

  // bipolar alternation every bit period; plain always because the
  // phase is preset in its declaration and never reset
  always @(posedge aclk) begin
    tog_r <= !tog_r;
  end
  assign pos = ~quiet & {CHANNELS{tog_r}};
  assign neg = ~quiet & {CHANNELS{!tog_r}};
endmodule

// ===== test/lai_top_tb_top.sv
// Purpose: self-checking bench of the line alarm interrupt logic
// Assumes: enables of channel 0 set, channel 1 left off
// Notes:   bus handshakes sampled and driven at the rising edge
`timescale 1ns/1ps
module lai_top_tb_top import lai_pkg::*;;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, tx_line_pos, tx_line_neg, quiet;
  logic [1:0]  rx_signal_loss, test_pattern_detect, line_alarm_irq;
  int          err_count = 0, samples_checked = 0, cyc = 0;

  lai_top i_lai_top (.*);
  lai_line_model #(.CHANNELS(2)) i_lai_line_model (.aclk(aclk), .quiet(quiet),
    .pos(tx_line_pos), .neg(tx_line_neg));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic stop_test;
    if (err_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // write one word; each channel released at its own take edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    fork
      begin
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (s_axi_wready !== 1'b1);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk({30'h0, s_axi_bresp}, {30'h0, r});
    s_axi_bready <= 1'b0;
  endtask
  // read one word and judge data and answer code
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    // data taken at the edge that accepts the answer
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
    s_axi_rready <= 1'b0;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    rdchk(8'h00, 32'h0, LAI_RESP_OKAY);
    rdchk(8'h04, 32'h0, LAI_RESP_OKAY);
    wr(8'h00, 32'hffffffff, LAI_RESP_OKAY);
    wr(8'h04, 32'hffffffff, LAI_RESP_OKAY);
    wr(8'h08, 32'hffffffff, LAI_RESP_SLVERR);
    rdchk(8'h00, 32'h43, LAI_RESP_OKAY);
    rdchk(8'h04, 32'h0, LAI_RESP_OKAY);
    rdchk(8'h10, 32'h0, LAI_RESP_OKAY);
    rdchk(8'h08, 32'h0, LAI_RESP_SLVERR);
  endtask
  // each level change of both channels, only channel 0 enabled
  task automatic t_edges;
    for (int k = 0; k < 4; k++) begin
      @(posedge aclk);
      if (k < 2) begin
        rx_signal_loss <= ~rx_signal_loss;
      end else begin
        test_pattern_detect <= ~test_pattern_detect;
      end
      @(posedge aclk);
      #1 chk({30'h0, line_alarm_irq}, 32'h1);
      // pulse lasts one cycle only
      @(posedge aclk);
      #1 chk({30'h0, line_alarm_irq}, 32'h0);
    end
  endtask
  // silence the rails of both channels, count bits to alarm, then revive
  task automatic t_dmo;
    int n;
    n = 0;
    @(posedge aclk);
    // both channels go quiet; channel 1 has its enable off
    quiet <= 2'h3;
    do begin
      @(posedge aclk);
      #1 n++;
    end while (line_alarm_irq[0] !== 1'b1 && n < 300);
    chk(n, 32'd128);
    chk({30'h0, line_alarm_irq}, 32'h1);
    rdchk(8'h04, 32'h40, LAI_RESP_OKAY);
    rdchk(8'h14, 32'h40, LAI_RESP_OKAY);
    @(posedge aclk);
    quiet <= 2'h0;
    @(posedge aclk);
    #1 chk({30'h0, line_alarm_irq}, 32'h1);
    rdchk(8'h04, 32'h0, LAI_RESP_OKAY);
    rdchk(8'h14, 32'h0, LAI_RESP_OKAY);
  endtask

  // ------------------------------------------------------------
  // clock, watchdog, main sequence
  // ------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #50 aclk = !aclk;
  end
  // run needs some 200 cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      stop_test;
    end
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 10'h001;
    {quiet, rx_signal_loss, test_pattern_detect} = 6'h00;
    aresetn = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_edges;
    t_dmo;
    stop_test;
  end
endmodule
